// ### common/pcs_map.svh
// offsets, field positions, reset values and counts of the pc/stack block
// assumes: included by bare name from the bench and the design
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH
// wishbone byte offsets
`define PCS_ADR_PCL 8'h00
`define PCS_ADR_LATCH 8'h04
`define PCS_ADR_SP 8'h08
`define PCS_ADR_TOP_ENTRY_LOW 8'h0C
`define PCS_ADR_TOP_ENTRY_HIGH 8'h10
`define PCS_ADR_F0L 8'h14
`define PCS_ADR_F0H 8'h18
`define PCS_ADR_F1L 8'h1C
`define PCS_ADR_F1H 8'h20
`define PCS_ADR_PWR 8'h24
`define PCS_ADR_CFG 8'h28
// fields
`define PCS_PWR_OVF 1
`define PCS_PWR_UNF 0
`define PCS_CFG_FSE 0
`define PCS_FSE_RST 1'b1
// stack
`define PCS_SP_EMPTY 5'h1F
`define PCS_SP_FULL 5'h0F
`define PCS_TOS_EMPTY_IDX 4'hE
`define PCS_INT_VEC 15'h0004
// indirect map
`define PCS_LIN_BASE 16'h2000
`define PCS_LIN_LAST 16'h29AF
`define PCS_GPR_BYTES 12'h050
`define PCS_GPR_BASE 7'h20
`define PCS_BANK_SHIFT 7
`define PCS_PROG_BIT 15
// answer latencies in cycles from the taking edge
`define PCS_LAT_DATA 3
`define PCS_LAT_PROG 4
`endif

// ### common/pcs_pkg.sv
// types of the pc/stack/indirect block
// assumes: pcs_map.svh on the include path
package pcs_pkg;
    typedef enum logic [3:0] {
        OP_NONE, OP_NEXT, OP_CALL, OP_COMPUTED_CALL_BY_ACCUMULATOR, OP_INTVEC,
        OP_RET, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT, OP_BRW, OP_BRA, OP_WRPCL
    } pcs_op_t;

    typedef struct packed {
        pcs_op_t op;
        logic [10:0] operand;
        logic [7:0] w;
    } pcs_cmd_t;

    typedef struct packed {
        logic valid;
        logic sel;
        logic we;
        logic [7:0] wdata;
    } pcs_ind_req_t;

    typedef struct packed {
        logic valid;
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } pcs_dmem_req_t;

    typedef struct packed {
        logic valid;
        logic [14:0] addr;
    } pcs_pmem_req_t;
endpackage

// ### dv/pcs_mem_model.sv
// data and program memory model on the far side of the indirect unit
// assumes: same clock as the design; read data follows a request pulse
// by one cycle, holds two cycles, then turns to the inverse value
module pcs_mem_model (
    input wire logic clk_i,
    input pcs_pkg::pcs_dmem_req_t dmem_i,
    input pcs_pkg::pcs_pmem_req_t pmem_i,
    output logic [7:0] dmem_rdata_o,
    output logic [13:0] pmem_rdata_o
);
    logic [7:0] mem_q [0:4095];
    logic [1:0] age_q;

    initial begin
        age_q = 2'h2;
        dmem_rdata_o = 8'h5A;
        pmem_rdata_o = 14'h15A5;
    end

    always @(posedge clk_i) begin
        if (dmem_i.valid === 1'b1 || pmem_i.valid === 1'b1) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h2) begin
            age_q <= age_q + 2'h1;
        end
        if (dmem_i.valid === 1'b1) begin
            if (dmem_i.we === 1'b1) mem_q[dmem_i.addr] <= dmem_i.wdata;
            dmem_rdata_o <= mem_q[dmem_i.addr];
        end else if (age_q == 2'h1) begin
            // hold over: no stale value may pass for a good one
            dmem_rdata_o <= ~dmem_rdata_o;
        end
        if (pmem_i.valid === 1'b1) begin
            // program word pattern derived from its address
            pmem_rdata_o <= pmem_i.addr[13:0] ^ 14'h2A5C;
        end else if (age_q == 2'h1) begin
            pmem_rdata_o <= ~pmem_rdata_o;
        end
    end
endmodule

// ### dv/pcs_top_test.sv
// self-checking bench of the pc, return stack and indirect unit
// assumes: pcs_map.svh on the include path, memory model beside the design
`include "pcs_map.svh"
module pcs_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic stack_reset_o;
    logic ind_ack_o;
    logic [7:0] dmem_rdata_i;
    logic [7:0] ind_rdata_o;
    logic [13:0] pmem_rdata_i;
    logic [14:0] pc_o;
    pcs_pkg::pcs_cmd_t cmd_i = '{pcs_pkg::OP_NONE, 11'h000, 8'h00};
    pcs_pkg::pcs_ind_req_t ind_i = '{1'b0, 1'b0, 1'b0, 8'h00};
    pcs_pkg::pcs_dmem_req_t dmem_o;
    pcs_pkg::pcs_pmem_req_t pmem_o;
    int err_count = 0;
    int compares = 0;
    int srst_count = 0;
    int dwr_count = 0;
    int n_dat;
    int n_prog;
    int base;
    logic [7:0] q;

    always #20 clk_i = ~clk_i;

    pcs_top #(.GPR_BANKS(2)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_i(cmd_i),
        .ind_i(ind_i), .dmem_rdata_i(dmem_rdata_i),
        .pmem_rdata_i(pmem_rdata_i), .pc_o(pc_o),
        .stack_reset_o(stack_reset_o), .ind_rdata_o(ind_rdata_o),
        .ind_ack_o(ind_ack_o), .dmem_o(dmem_o), .pmem_o(pmem_o));

    pcs_mem_model i_mem (.clk_i(clk_i), .dmem_i(dmem_o), .pmem_i(pmem_o),
        .dmem_rdata_o(dmem_rdata_i), .pmem_rdata_o(pmem_rdata_i));

    // pulse counters sampled mid-cycle, clear of the clock edge
    always @(negedge clk_i) begin
        if (stack_reset_o === 1'b1) srst_count++;
        if (dmem_o.valid === 1'b1 && dmem_o.we === 1'b1) dwr_count++;
    end

    task automatic final_report();
        if (err_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic wb_xfer(input logic we, input logic [7:0] adr,
        input logic [7:0] dat, output logic [31:0] rdat);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h00_0000, dat};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) begin
            err_count++;
            final_report();
        end
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] rdat;
        wb_xfer(1'b1, adr, dat, rdat);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
        logic [31:0] rdat;
        wb_xfer(1'b0, adr, 8'h00, rdat);
        check(rdat, {24'h00_0000, exp});
    endtask

    task automatic pc_chk(input logic [14:0] exp);
        check({17'h0_0000, pc_o}, {17'h0_0000, exp});
    endtask

    task automatic op(input pcs_pkg::pcs_op_t o, input logic [10:0] opd,
        input logic [7:0] w);
        cmd_i <= '{o, opd, w};
        @(posedge clk_i);
        cmd_i <= '{pcs_pkg::OP_NONE, 11'h000, 8'h00};
        @(posedge clk_i);
    endtask

    task automatic ptr(input logic sel, input logic [15:0] a);
        wr(sel ? `PCS_ADR_F1L : `PCS_ADR_F0L, a[7:0]);
        wr(sel ? `PCS_ADR_F1H : `PCS_ADR_F0H, a[15:8]);
    endtask

    // one-cycle request: the unit is idle, so the first edge takes it
    task automatic ind(input logic sel, input logic we, input logic [7:0] wd,
        output logic [7:0] rdat, output int n);
        ind_i <= '{1'b1, sel, we, wd};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            ind_i.valid <= 1'b0;
        end while (ind_ack_o !== 1'b1 && n < 50);
        if (ind_ack_o !== 1'b1) begin
            err_count++;
            final_report();
        end
        rdat = ind_rdata_o;
        @(posedge clk_i);
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        pc_chk(15'h0000);
        rd_chk(`PCS_ADR_SP, 8'h1F);
        rd_chk(`PCS_ADR_PWR, 8'h00);
        rd_chk(8'h3C, 8'h00);
        wr(`PCS_ADR_LATCH, 8'h55);
        wr(`PCS_ADR_PCL, 8'h12);
        pc_chk(15'h5512);
        rd_chk(`PCS_ADR_PCL, 8'h12);
        op(pcs_pkg::OP_CALL, 11'h123, 8'h00);
        pc_chk(15'h5123);
        rd_chk(`PCS_ADR_SP, 8'h00);
        rd_chk(`PCS_ADR_TOP_ENTRY_LOW, 8'h13);
        rd_chk(`PCS_ADR_TOP_ENTRY_HIGH, 8'h55);
        op(pcs_pkg::OP_COMPUTED_CALL_BY_ACCUMULATOR, 11'h000, 8'h34);
        pc_chk(15'h5534);
        op(pcs_pkg::OP_BRW, 11'h000, 8'hF0);
        pc_chk(15'h5625);
        op(pcs_pkg::OP_BRA, 11'h1FE, 8'h00);
        pc_chk(15'h5624);
        op(pcs_pkg::OP_RET, 11'h000, 8'h00);
        pc_chk(15'h5124);
        op(pcs_pkg::OP_RETURN_WITH_LITERAL, 11'h000, 8'h00);
        pc_chk(15'h5513);
        rd_chk(`PCS_ADR_LATCH, 8'h55);
        op(pcs_pkg::OP_RETURN_FROM_INTERRUPT, 11'h000, 8'h00);
        check(32'(srst_count), 32'h0000_0001);
        pc_chk(15'h0000);
        rd_chk(`PCS_ADR_PWR, 8'h01);
        wr(`PCS_ADR_PWR, 8'h00);
        wr(`PCS_ADR_CFG, 8'h00);
        wr(`PCS_ADR_LATCH, 8'h00);
        for (int i = 0; i < 17; i++) begin
            op(pcs_pkg::OP_CALL, 11'h100 + 11'(i), 8'h00);
        end
        check(32'(srst_count), 32'h0000_0001);
        pc_chk(15'h0110);
        rd_chk(`PCS_ADR_PWR, 8'h02);
        wr(`PCS_ADR_SP, 8'h00);
        rd_chk(`PCS_ADR_TOP_ENTRY_LOW, 8'h10);
        rd_chk(`PCS_ADR_TOP_ENTRY_HIGH, 8'h01);
        wr(`PCS_ADR_SP, 8'h1F);
        rd_chk(`PCS_ADR_TOP_ENTRY_LOW, 8'h0E);
        wr(`PCS_ADR_CFG, 8'h01);
        rd_chk(`PCS_ADR_TOP_ENTRY_LOW, 8'h00);
        wr(`PCS_ADR_SP, 8'h03);
        wr(`PCS_ADR_TOP_ENTRY_LOW, 8'hAB);
        wr(`PCS_ADR_TOP_ENTRY_HIGH, 8'h12);
        op(pcs_pkg::OP_RET, 11'h000, 8'h00);
        pc_chk(15'h12AB);
        rd_chk(`PCS_ADR_SP, 8'h02);
        wr(`PCS_ADR_PWR, 8'h00);
        wr(`PCS_ADR_SP, 8'h0F);
        op(pcs_pkg::OP_CALL, 11'h010, 8'h00);
        check(32'(srst_count), 32'h0000_0002);
        pc_chk(15'h0000);
        rd_chk(`PCS_ADR_SP, 8'h1F);
        rd_chk(`PCS_ADR_PWR, 8'h02);
        wr(`PCS_ADR_PCL, 8'h40);
        op(pcs_pkg::OP_INTVEC, 11'h000, 8'h00);
        pc_chk(`PCS_INT_VEC);
        rd_chk(`PCS_ADR_TOP_ENTRY_LOW, 8'h40);
        op(pcs_pkg::OP_NEXT, 11'h000, 8'h00);
        pc_chk(15'h0005);
        op(pcs_pkg::OP_WRPCL, 11'h000, 8'h77);
        pc_chk(15'h0077);
        // indirect access over both pointers and every region
        ptr(1'b0, 16'h0123);
        ind(1'b0, 1'b1, 8'h5A, q, n_dat);
        ind(1'b0, 1'b0, 8'h00, q, n_dat);
        check({24'h00_0000, q}, 32'h0000_005A);
        ptr(1'b1, 16'h2051);
        ind(1'b1, 1'b1, 8'h77, q, n_prog);
        ptr(1'b0, 16'h00A1);
        ind(1'b0, 1'b0, 8'h00, q, n_prog);
        check({24'h00_0000, q}, 32'h0000_0077);
        base = dwr_count;
        ptr(1'b0, 16'h0081);
        ind(1'b0, 1'b0, 8'h00, q, n_prog);
        check({24'h00_0000, q}, 32'h0000_0000);
        ind(1'b0, 1'b1, 8'h33, q, n_prog);
        ptr(1'b0, 16'h20A0);
        ind(1'b0, 1'b0, 8'h00, q, n_prog);
        check({24'h00_0000, q}, 32'h0000_0000);
        ptr(1'b0, 16'h1000);
        ind(1'b0, 1'b0, 8'h00, q, n_prog);
        check({24'h00_0000, q}, 32'h0000_0000);
        ind(1'b0, 1'b1, 8'h44, q, n_prog);
        ptr(1'b1, 16'h8123);
        ind(1'b1, 1'b0, 8'h00, q, n_prog);
        check({24'h00_0000, q}, 32'h0000_007F);
        check(32'(n_prog), 32'(n_dat + 1));
        ind(1'b1, 1'b1, 8'h99, q, n_prog);
        check(32'(dwr_count), 32'(base));
        // second reset in mid-run
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        pc_chk(15'h0000);
        rd_chk(`PCS_ADR_SP, 8'h1F);
        final_report();
    end
endmodule

// ### rtl/pcs_top.sv
// program counter, return stack and indirect address unit of an 8-bit core
// assumes: decoder and memories on clk_i; data memory and program memory
// present read data one cycle after their request pulse and hold it two cycles
//
// Overview of operation
// - 15-bit pc; low byte read/write, bits 14:8 come from high latch
// - any reset clears the whole pc
// - writing the low byte loads bits 14:8 from the high latch
// - call loads bits 10:0 from operand, 14:11 from latch bits 6:3
// - computed call: low byte from accumulator, upper seven from latch
// - branch by accumulator: pc becomes pc+1 plus unsigned accumulator
// - relative jump: pc becomes pc+1 plus sign-extended operand bits 8:0
// - sixteen entry, 15-bit return stack outside program and data space
// - push on calls and interrupts, pop on returns; latch untouched
// - fault reset off: stack wraps, seventeenth push overwrites entry 0
// - overflow and underflow flags set whether or not fault reset is on
// - five-bit pointer and top entry pair reach the pointed entry
// - push increments pointer then stores; return reloads then decrements
// - pointer resets to empty value 0x1F
// - empty stack reads zero with fault reset on, else entry 0x0E
// - fault reset on: overflow or underflow resets and sets the flag
// - window reaches pointer target; window-to-window reads 0, no write
// - each pointer is 16 bits from high and low byte registers
// - pointer 0x000 to 0xFFF maps to absolute banked data addresses
// - 0x2000 to 0x29AF maps onto 80-byte blocks of successive banks
// - unimplemented linear locations read 0x00
// - top pointer bit selects program memory, low byte only, no write
// - program memory through a pointer costs one extra cycle
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`include "pcs_map.svh"
module pcs_top #(
    parameter int GPR_BANKS = 31
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input pcs_pkg::pcs_cmd_t cmd_i,
    input pcs_pkg::pcs_ind_req_t ind_i,
    input wire logic [7:0] dmem_rdata_i,
    input wire logic [13:0] pmem_rdata_i,
    output logic [14:0] pc_o,
    output logic stack_reset_o,
    output logic [7:0] ind_rdata_o,
    output logic ind_ack_o,
    output pcs_pkg::pcs_dmem_req_t dmem_o,
    output pcs_pkg::pcs_pmem_req_t pmem_o
);
    typedef enum logic [2:0] {
        S_IDLE, S_DREQ, S_DCAP, S_PREQ, S_PEXT, S_PCAP
    } pcs_ind_st_t;

    logic [14:0] pc_q;
    logic [6:0] latch_q;
    logic [4:0] sp_q;
    logic [14:0] stack_q [16];
    logic [15:0] fsr_q [2];
    logic [1:0] pwr_q;
    logic fse_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic rst_pulse_q;
    pcs_ind_st_t st_q;
    logic [7:0] irdata_q;
    logic iack_q;
    pcs_pkg::pcs_dmem_req_t dreq_q;
    pcs_pkg::pcs_pmem_req_t preq_q;

    // ---- command decode
    logic [14:0] pc_inc;
    logic is_push, is_pop, ovf, unf, fault;
    logic [4:0] sp_up;
    logic [14:0] tos_val;
    assign pc_inc = pc_q + 15'h0001;
    assign sp_up = sp_q + 5'h01;
    assign is_push = cmd_i.op inside {pcs_pkg::OP_CALL, pcs_pkg::OP_COMPUTED_CALL_BY_ACCUMULATOR,
                                      pcs_pkg::OP_INTVEC};
    assign is_pop = cmd_i.op inside {pcs_pkg::OP_RET, pcs_pkg::OP_RETURN_WITH_LITERAL,
                                     pcs_pkg::OP_RETURN_FROM_INTERRUPT};
    assign ovf = is_push && sp_q == `PCS_SP_FULL;
    assign unf = is_pop && sp_q == `PCS_SP_EMPTY;
    assign fault = fse_q && (ovf || unf);

    // top entry as software sees it
    always_comb begin
        if (sp_q == `PCS_SP_EMPTY) begin
            tos_val = fse_q ? 15'h0000 : stack_q[`PCS_TOS_EMPTY_IDX];
        end else begin
            tos_val = stack_q[sp_q[3:0]];
        end
    end

    // ---- wishbone
    logic bus_req, bus_wr;
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (bus_req) begin
            if (wb_adr_i == `PCS_ADR_PCL) begin
                rdat_q <= {24'h00_0000, pc_q[7:0]};
            end else if (wb_adr_i == `PCS_ADR_LATCH) begin
                rdat_q <= {25'h000_0000, latch_q};
            end else if (wb_adr_i == `PCS_ADR_SP) begin
                rdat_q <= {27'h000_0000, sp_q};
            end else if (wb_adr_i == `PCS_ADR_TOP_ENTRY_LOW) begin
                rdat_q <= {24'h00_0000, tos_val[7:0]};
            end else if (wb_adr_i == `PCS_ADR_TOP_ENTRY_HIGH) begin
                rdat_q <= {25'h000_0000, tos_val[14:8]};
            end else if (wb_adr_i == `PCS_ADR_F0L) begin
                rdat_q <= {24'h00_0000, fsr_q[0][7:0]};
            end else if (wb_adr_i == `PCS_ADR_F0H) begin
                rdat_q <= {24'h00_0000, fsr_q[0][15:8]};
            end else if (wb_adr_i == `PCS_ADR_F1L) begin
                rdat_q <= {24'h00_0000, fsr_q[1][7:0]};
            end else if (wb_adr_i == `PCS_ADR_F1H) begin
                rdat_q <= {24'h00_0000, fsr_q[1][15:8]};
            end else if (wb_adr_i == `PCS_ADR_PWR) begin
                rdat_q <= {30'h0000_0000, pwr_q};
            end else if (wb_adr_i == `PCS_ADR_CFG) begin
                rdat_q <= {31'h0000_0000, fse_q};
            end else begin
                rdat_q <= 32'h0000_0000;
            end
        end
    end

    // ---- program counter
    always_ff @(posedge clk_i) begin
        if (rst_i || fault) begin
            pc_q <= 15'h0000;
        end else begin
            case (cmd_i.op)
                pcs_pkg::OP_NEXT: pc_q <= pc_inc;
                pcs_pkg::OP_CALL: begin
                    pc_q <= {latch_q[6:3], cmd_i.operand};
                end
                pcs_pkg::OP_COMPUTED_CALL_BY_ACCUMULATOR: begin
                    pc_q <= {latch_q, cmd_i.w};
                end
                pcs_pkg::OP_INTVEC: pc_q <= `PCS_INT_VEC;
                pcs_pkg::OP_RET, pcs_pkg::OP_RETURN_WITH_LITERAL,
                pcs_pkg::OP_RETURN_FROM_INTERRUPT: begin
                    pc_q <= stack_q[sp_q[3:0]];
                end
                pcs_pkg::OP_BRW: begin
                    pc_q <= pc_inc + {7'h00, cmd_i.w};
                end
                pcs_pkg::OP_BRA: begin
                    pc_q <= pc_inc + {{6{cmd_i.operand[8]}},
                                      cmd_i.operand[8:0]};
                end
                pcs_pkg::OP_WRPCL: begin
                    pc_q <= {latch_q, cmd_i.w};
                end
                default: begin
                    if (bus_wr && wb_adr_i == `PCS_ADR_PCL) begin
                        pc_q <= {latch_q, wb_dat_i[7:0]};
                    end
                end
            endcase
        end
    end

    // latch is only touched by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q <= 7'h00;
        end else if (bus_wr && wb_adr_i == `PCS_ADR_LATCH) begin
            latch_q <= wb_dat_i[6:0];
        end
    end

    // ---- stack pointer and entries
    always_ff @(posedge clk_i) begin
        if (rst_i || fault) begin
            sp_q <= `PCS_SP_EMPTY;
        end else if (is_push) begin
            sp_q <= sp_up;
        end else if (is_pop) begin
            sp_q <= sp_q - 5'h01;
        end else if (bus_wr && wb_adr_i == `PCS_ADR_SP) begin
            sp_q <= wb_dat_i[4:0];
        end
    end

    // entries have no reset; index wraps so entry 0 follows entry 15
    always_ff @(posedge clk_i) begin
        if (is_push && !fault && !rst_i) begin
            if (cmd_i.op == pcs_pkg::OP_INTVEC) begin
                stack_q[sp_up[3:0]] <= pc_q;
            end else begin
                stack_q[sp_up[3:0]] <= pc_inc;
            end
        end else if (bus_wr && wb_adr_i == `PCS_ADR_TOP_ENTRY_LOW) begin
            stack_q[sp_q[3:0]][7:0] <= wb_dat_i[7:0];
        end else if (bus_wr && wb_adr_i == `PCS_ADR_TOP_ENTRY_HIGH) begin
            stack_q[sp_q[3:0]][14:8] <= wb_dat_i[6:0];
        end
    end

    // flags: a set in the clearing cycle wins
    logic [1:0] pwr_set, pwr_clr;
    assign pwr_set = {ovf, unf};
    assign pwr_clr = (bus_wr && wb_adr_i == `PCS_ADR_PWR) ?
                     ~wb_dat_i[1:0] : 2'b00;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_q <= 2'b00;
        end else begin
            pwr_q <= (pwr_q & ~pwr_clr) | pwr_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fse_q <= `PCS_FSE_RST;
        end else if (bus_wr && wb_adr_i == `PCS_ADR_CFG) begin
            fse_q <= wb_dat_i[`PCS_CFG_FSE];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_pulse_q <= 1'b0;
        end else begin
            rst_pulse_q <= fault;
        end
    end

    // ---- file select pointers
    for (genvar g = 0; g < 2; g++) begin : g_fsr
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                fsr_q[g] <= 16'h0000;
            end else if (bus_wr && wb_adr_i == (g ? `PCS_ADR_F1L
                                                  : `PCS_ADR_F0L)) begin
                fsr_q[g][7:0] <= wb_dat_i[7:0];
            end else if (bus_wr && wb_adr_i == (g ? `PCS_ADR_F1H
                                                  : `PCS_ADR_F0H)) begin
                fsr_q[g][15:8] <= wb_dat_i[7:0];
            end
        end
    end

    // ---- indirect address map
    logic [15:0] fa;
    logic [11:0] loff, bofs, dabs;
    logic [4:0] bank;
    logic is_trad, is_lin, is_prog, is_dat;
    assign fa = fsr_q[ind_i.sel];
    assign loff = 12'(fa - `PCS_LIN_BASE);
    assign bank = 5'(loff / `PCS_GPR_BYTES);
    assign bofs = 12'(loff - 12'(bank) * `PCS_GPR_BYTES);
    assign is_prog = fa[`PCS_PROG_BIT];
    assign is_trad = fa[15:12] == 4'h0;
    assign is_lin = fa >= `PCS_LIN_BASE && fa <= `PCS_LIN_LAST
                    && 32'(bank) < GPR_BANKS;
    // window registers sit at offsets 0 and 1 of every bank
    assign is_dat = (is_trad && fa[6:1] != 6'h00) || is_lin;
    always_comb begin
        if (is_lin) begin
            dabs = {bank, `PCS_GPR_BASE + bofs[6:0]};
        end else begin
            dabs = fa[11:0];
        end
    end

    logic ind_take;
    assign ind_take = ind_i.valid && st_q == S_IDLE;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= S_IDLE;
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (ind_take && !ind_i.we) begin
                        if (is_prog) begin
                            st_q <= S_PREQ;
                        end else if (is_dat) begin
                            st_q <= S_DREQ;
                        end
                    end
                end
                S_DREQ: st_q <= S_DCAP;
                S_PREQ: st_q <= S_PEXT;
                S_PEXT: st_q <= S_PCAP;
                default: st_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dreq_q <= '0;
        end else if (ind_take && !is_prog && is_dat) begin
            dreq_q.valid <= 1'b1;
            dreq_q.we <= ind_i.we;
            dreq_q.addr <= dabs;
            dreq_q.wdata <= ind_i.wdata;
        end else begin
            dreq_q.valid <= 1'b0;
            dreq_q.we <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            preq_q <= '0;
        end else if (ind_take && is_prog && !ind_i.we) begin
            preq_q.valid <= 1'b1;
            preq_q.addr <= fa[14:0];
        end else begin
            preq_q.valid <= 1'b0;
        end
    end

    // answer: zero and write cases next cycle, data after 3, program 4
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            iack_q <= 1'b0;
            irdata_q <= 8'h00;
        end else if (ind_take && (ind_i.we || (!is_prog && !is_dat))) begin
            iack_q <= 1'b1;
            irdata_q <= 8'h00;
        end else if (st_q == S_DCAP) begin
            iack_q <= 1'b1;
            irdata_q <= dmem_rdata_i;
        end else if (st_q == S_PCAP) begin
            iack_q <= 1'b1;
            irdata_q <= pmem_rdata_i[7:0];
        end else begin
            iack_q <= 1'b0;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign pc_o = pc_q;
    assign stack_reset_o = rst_pulse_q;
    assign ind_rdata_o = irdata_q;
    assign ind_ack_o = iack_q;
    assign dmem_o = dreq_q;
    assign pmem_o = preq_q;

    // ---- checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_PC_RESET: assert property (
        $rose(stack_reset_o) |-> pc_o == 15'h0000 && sp_q == 5'h1F)
        else $error("pc or pointer not cleared by stack fault");
    AST_PCL_WRITE: assert property (
        cmd_i.op == pcs_pkg::OP_WRPCL |=>
        pc_o == {$past(latch_q), $past(cmd_i.w)})
        else $error("low byte write did not load latch");
    AST_CALL: assert property (
        cmd_i.op == pcs_pkg::OP_CALL && !fault |=>
        pc_o[10:0] == $past(cmd_i.operand) &&
        pc_o[14:11] == $past(latch_q[6:3]))
        else $error("call target wrong");
    AST_BRW: assert property (
        cmd_i.op == pcs_pkg::OP_BRW |=>
        pc_o == 15'($past(pc_q) + 15'h0001 + $past(cmd_i.w)))
        else $error("branch by accumulator wrong");
    AST_PUSH: assert property (
        is_push && !fault |=> sp_q == 5'($past(sp_q) + 5'h01) &&
        stack_q[sp_q[3:0]] == (($past(cmd_i.op) == pcs_pkg::OP_INTVEC) ?
        $past(pc_q) : 15'($past(pc_q) + 15'h0001)))
        else $error("push did not advance pointer or store pc");
    AST_RET: assert property (
        is_pop && !fault |=> pc_o == $past(stack_q[sp_q[3:0]]) &&
        sp_q == 5'($past(sp_q) - 5'h01))
        else $error("return did not reload pc then step pointer");
    AST_OVF_FLAG: assert property (
        ovf |=> pwr_q[`PCS_PWR_OVF] ##1 1'b1)
        else $error("overflow flag not set");
    AST_FAULT_RST: assert property (
        fse_q && unf |=> stack_reset_o ##1 !stack_reset_o)
        else $error("underflow did not pulse reset once");
    AST_SELF_ZERO: assert property (
        ind_take && !ind_i.we && is_trad && fa[6:1] == 6'h00 |=>
        ind_ack_o && ind_rdata_o == 8'h00 && !dmem_o.valid)
        else $error("window-to-window read not zero");
    AST_PROG_LAT: assert property (
        ind_take && is_prog && !ind_i.we |->
        ##1 !ind_ack_o [*3] ##1 ind_ack_o)
        else $error("program read latency not four");
    AST_PROG_NOWR: assert property (
        ind_take && is_prog && ind_i.we |=> !dmem_o.valid && !pmem_o.valid)
        else $error("write through program path went out");
    COV_PUSH_POP: cover property (is_push ##[1:20] is_pop);
    COV_WRAP: cover property (ovf && !fse_q);
    COV_LIN: cover property (ind_take && is_lin);
    COV_PROG: cover property (ind_take && is_prog);
endmodule
